// [verilog/arp_regs.svh]
`ifndef ARP_REGS_SVH
`define ARP_REGS_SVH

// system clock period
`define ARP_CLK_PERIOD_PS 5000
`define ARP_SAMPLE_BITS 16
// sample buffer address width, one frame (left and right) per word
`define ARP_BUF_AW 14
`define ARP_BUF_LAST 14'h3F_FF
// nco step for the codec master clock: 2^32 * 18.432 / 200
`define ARP_MCLK_INC 32'h1797_CC3A
// button lockout after any level change
`define ARP_DEBOUNCE_NS 10000000
// i2c quarter bit period, 100 kbit/s
`define ARP_I2C_QUARTER_NS 2500
`define ARP_I2C_QUARTER_CYC (`ARP_I2C_QUARTER_NS * 1000 / `ARP_CLK_PERIOD_PS)
`define ARP_I2C_SLOTS 5'h1B
`define ARP_I2C_WORDS 3'h5
// power-on value of the input synchronisers, buttons idle high
`define ARP_SYNC_RST 9'h018
// codec bus address and configuration words (register index and data)
`define ARP_CODEC_ADDR 8'h34
`define ARP_CW_POWER 16'h0C00
`define ARP_CW_PATH 16'h0810
`define ARP_CW_MIC_BIT 16'h0004
`define ARP_CW_FORMAT 16'h0E42
`define ARP_CW_RATE 16'h1000
`define ARP_CW_RATE_LSB 2
`define ARP_CW_ACTIVE 16'h1201
// rate field codes
`define ARP_SR_96K 4'h7
`define ARP_SR_48K 4'h0
`define ARP_SR_44K1 4'h8
`define ARP_SR_32K 4'h6
`define ARP_SR_8K 4'h3

`endif

// [verilog/arp_pkg.sv]
package arp_pkg;
  typedef enum logic [1:0] {
    ARP_ST_IDLE = 2'b00,
    ARP_ST_REC = 2'b01,
    ARP_ST_PLAY = 2'b10
  } arp_state_t;

  typedef enum logic [2:0] {
    ARP_I2C_IDLE = 3'b000,
    ARP_I2C_START = 3'b001,
    ARP_I2C_BIT = 3'b010,
    ARP_I2C_STOP = 3'b011,
    ARP_I2C_NEXT = 3'b100
  } arp_i2c_state_t;
endpackage

// [verilog/arp_i2c_cfg.sv]
`timescale 1ns/1ps
`include "arp_regs.svh"
module arp_i2c_cfg
  import arp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_sync_n, // synchronised reset
  input wire logic start, // pulse: rewrite whole configuration
  input wire logic mic_select, // 1 picks microphone input
  input wire logic [3:0] rate_code, // codec rate field
  input wire logic sda_i, // data line level
  output logic scl_oe, // pulls clock line low
  output logic sda_oe, // pulls data line low
  output logic busy, // sequence running or pending
  output logic nack // a slot saw no acknowledge
);
  arp_i2c_state_t st_reg, st_next;
  logic [9:0] q_reg, q_next;
  logic [1:0] ph_reg, ph_next;
  logic [4:0] slot_reg, slot_next;
  logic [2:0] word_reg, word_next;
  logic pend_reg, pend_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic busy_reg, busy_next, nack_reg, nack_next;
  logic sda_m_reg, sda_s_reg;
  logic [15:0] cw;
  logic [26:0] frame;
  logic tick, ack_slot;

  always_comb
  begin
    case (word_reg)
      3'h0: cw = `ARP_CW_POWER;
      3'h1: cw = mic_select ? (`ARP_CW_PATH | `ARP_CW_MIC_BIT)
                            : `ARP_CW_PATH;
      3'h2: cw = `ARP_CW_FORMAT;
      3'h3: cw = `ARP_CW_RATE | (16'(rate_code) << `ARP_CW_RATE_LSB);
      default: cw = `ARP_CW_ACTIVE;
    endcase
  end

  // ones in the ack slots release the data line
  assign frame = {`ARP_CODEC_ADDR, 1'b1, cw[15:8], 1'b1, cw[7:0], 1'b1};
  assign tick = (q_reg == 10'(`ARP_I2C_QUARTER_CYC - 1));
  assign ack_slot = (slot_reg == 5'd8) || (slot_reg == 5'd17) ||
                    (slot_reg == 5'd26);

  always_comb
  begin
    st_next = st_reg;
    q_next = tick ? 10'h000 : q_reg + 10'h001;
    ph_next = ph_reg;
    slot_next = slot_reg;
    word_next = word_reg;
    pend_next = pend_reg | start;
    scl_next = scl_reg;
    sda_next = sda_reg;
    nack_next = nack_reg;
    if (tick)
    begin
      ph_next = ph_reg + 2'h1;
      case (st_reg)
        ARP_I2C_IDLE:
        begin
          ph_next = 2'h0;
          if (pend_reg)
          begin
            // a request arriving now re-arms, so no change is lost
            pend_next = start;
            nack_next = 1'b0;
            word_next = 3'h0;
            st_next = ARP_I2C_START;
          end
        end
        ARP_I2C_START:
        begin
          if (ph_reg == 2'h1)
            sda_next = 1'b1;
          if (ph_reg == 2'h3)
          begin
            scl_next = 1'b1;
            slot_next = 5'h00;
            st_next = ARP_I2C_BIT;
          end
        end
        ARP_I2C_BIT:
        begin
          if (ph_reg == 2'h0)
            sda_next = ~frame[5'd26 - slot_reg];
          if (ph_reg == 2'h1)
            scl_next = 1'b0;
          if (ph_reg == 2'h2 && ack_slot && sda_s_reg)
            nack_next = 1'b1;
          if (ph_reg == 2'h3)
          begin
            scl_next = 1'b1;
            slot_next = slot_reg + 5'h01;
            if (slot_reg == `ARP_I2C_SLOTS - 5'h01)
              st_next = ARP_I2C_STOP;
          end
        end
        ARP_I2C_STOP:
        begin
          if (ph_reg == 2'h0)
            sda_next = 1'b1;
          if (ph_reg == 2'h1)
            scl_next = 1'b0;
          if (ph_reg == 2'h2)
            sda_next = 1'b0;
          if (ph_reg == 2'h3)
            st_next = ARP_I2C_NEXT;
        end
        default:
        begin
          if (ph_reg == 2'h3)
          begin
            word_next = word_reg + 3'h1;
            st_next = (word_reg == `ARP_I2C_WORDS - 3'h1) ? ARP_I2C_IDLE
                                                          : ARP_I2C_START;
          end
        end
      endcase
    end
    busy_next = pend_next || (st_next != ARP_I2C_IDLE);
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st_reg <= ARP_I2C_IDLE;
      q_reg <= 10'h000;
      ph_reg <= 2'h0;
      slot_reg <= 5'h00;
      word_reg <= 3'h0;
      pend_reg <= 1'b0;
      scl_reg <= 1'b0;
      sda_reg <= 1'b0;
      busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      q_reg <= q_next;
      ph_reg <= ph_next;
      slot_reg <= slot_next;
      word_reg <= word_next;
      pend_reg <= pend_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      busy_reg <= busy_next;
      nack_reg <= nack_next;
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
    end
  end

  assign scl_oe = scl_reg;
  assign sda_oe = sda_reg;
  assign busy = busy_reg;
  assign nack = nack_reg;
endmodule // arp_i2c_cfg

// [verilog/arp_top.sv]
// What this block does
// - exchange 16-bit i2s samples, codec drives clocks
// - drive 18.432 MHz master clock to codec
// - source switch 0 picks mic, 1 line
// - rate switches pick 96K/48K/44.1K/32K/8K, else 96K
// - record button toggles recording on and off
// - recording indicator lit only while recording
// - play button toggles playback on and off
// - playing indicator lit only while playing
// - recording stops by itself when buffer full
// - playback stops when last stored sample starts being sent
// - configure codec over open-drain i2c pins
`timescale 1ns/1ps
`include "arp_regs.svh"
module arp_top
  import arp_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `ARP_DEBOUNCE_NS / (`ARP_CLK_PERIOD_PS / 1000)
)
(
  input wire logic clk, // 200 MHz system clock
  input wire logic rst_n, // asynchronous reset
  input wire logic source_select_switch, // 0 mic, 1 line in
  input wire logic rate_select_bit0, // rate switch lsb
  input wire logic rate_select_bit1, // rate switch middle
  input wire logic rate_select_bit2, // rate switch msb
  input wire logic record_toggle_button_n, // pressed low
  input wire logic play_toggle_button_n, // pressed low
  input wire logic codec_bclk, // serial bit clock from codec
  input wire logic codec_lrclk, // frame clock from codec
  input wire logic codec_adc_data, // serial record data
  input wire logic codec_scl_i, // i2c clock line level
  input wire logic codec_sda_i, // i2c data line level
  output logic recording_indicator, // lit while recording
  output logic playing_indicator, // lit while playing
  output logic codec_master_clock_input, // master clock to codec
  output logic codec_dac_data, // serial playback data
  output logic codec_scl_o, // i2c clock drive value
  output logic codec_scl_oe, // i2c clock pulled low
  output logic codec_sda_o, // i2c data drive value
  output logic codec_sda_oe, // i2c data pulled low
  output logic codec_cfg_busy, // configuration in progress
  output logic codec_nack // codec missed an acknowledge
);
  localparam logic [`ARP_BUF_AW:0] LEN_ONE = 1;

  logic [1:0] rst_pipe_reg;
  logic rst_sync_n;
  logic [8:0] meta_reg, sync_reg;
  logic [1:0] btn_now, btn_prev_reg, press;
  logic [1:0][31:0] lock_reg, lock_next;
  logic [31:0] nco_reg;
  arp_state_t st_reg, st_next;
  logic bclk_prev_reg, lr_prev_reg, lr_prev_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [15:0] rx_sh_reg, rx_sh_next, left_reg, left_next;
  logic [15:0] tx_sh_reg, tx_sh_next, right_hold_reg, right_hold_next;
  logic dac_reg, dac_next;
  logic [`ARP_BUF_AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [`ARP_BUF_AW:0] len_reg, len_next;
  logic [31:0] mem [0:(1 << `ARP_BUF_AW)-1];
  logic [31:0] play_word_reg;
  logic mem_we;
  logic rise, fall, lr_now, lr_change;
  logic rec_led_reg, play_led_reg;
  logic [3:0] rate_code;
  logic [4:0] set_reg;
  logic cfg_start_reg, init_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe_reg <= 2'b00;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe_reg[1];

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      meta_reg <= `ARP_SYNC_RST;
      sync_reg <= `ARP_SYNC_RST;
    end
    else
    begin
      meta_reg <= {source_select_switch, rate_select_bit2, rate_select_bit1,
                   rate_select_bit0, record_toggle_button_n,
                   play_toggle_button_n, codec_bclk, codec_lrclk,
                   codec_adc_data};
      sync_reg <= meta_reg;
    end
  end

  // any level change restarts the lockout, so release bounce is ignored too
  assign btn_now = sync_reg[4:3];
  for (genvar i = 0; i < 2; i++)
  begin : g_btn
    always_comb
    begin
      lock_next[i] = lock_reg[i];
      press[i] = 1'b0;
      if (btn_now[i] != btn_prev_reg[i])
      begin
        press[i] = (lock_reg[i] == 32'h0000_0000) && !btn_now[i];
        lock_next[i] = 32'(DEBOUNCE_CYC);
      end
      else if (lock_reg[i] != 32'h0000_0000)
        lock_next[i] = lock_reg[i] - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      btn_prev_reg <= 2'b11;
      lock_reg <= '0;
    end
    else
    begin
      btn_prev_reg <= btn_now;
      lock_reg <= lock_next;
    end
  end

  // fractional nco: average 18.432 MHz to within the step rounding, one system period of jitter
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      nco_reg <= 32'h0000_0000;
    else
      nco_reg <= nco_reg + `ARP_MCLK_INC;
  end

  always_comb
  begin
    case (sync_reg[7:5])
      3'b001: rate_code = `ARP_SR_48K;
      3'b010: rate_code = `ARP_SR_44K1;
      3'b011: rate_code = `ARP_SR_32K;
      3'b100: rate_code = `ARP_SR_8K;
      default: rate_code = `ARP_SR_96K;
    endcase
  end

  // rewrite the codec at start-up and whenever the selected source or decoded rate code changes
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      set_reg <= 5'h00;
      init_reg <= 1'b1;
      cfg_start_reg <= 1'b0;
    end
    else
    begin
      set_reg <= {sync_reg[8], rate_code};
      init_reg <= 1'b0;
      cfg_start_reg <= init_reg || (set_reg != {sync_reg[8], rate_code});
    end
  end

  assign rise = sync_reg[2] && !bclk_prev_reg;
  assign fall = !sync_reg[2] && bclk_prev_reg;
  assign lr_now = sync_reg[1];
  assign lr_change = rise && (lr_now != lr_prev_reg);

  always_comb
  begin
    st_next = st_reg;
    lr_prev_next = lr_prev_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_sh_next = rx_sh_reg;
    left_next = left_reg;
    tx_sh_next = tx_sh_reg;
    right_hold_next = right_hold_reg;
    dac_next = dac_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    len_next = len_reg;
    mem_we = 1'b0;
    if (rise)
    begin
      lr_prev_next = lr_now;
      if (lr_change)
        bit_cnt_next = 5'h00;
      else if (bit_cnt_reg != 5'h1F)
        bit_cnt_next = bit_cnt_reg + 5'h01;
      // msb comes one bit clock after the frame clock edge
      if (!lr_change && bit_cnt_reg < 5'(`ARP_SAMPLE_BITS))
        rx_sh_next = {rx_sh_reg[14:0], sync_reg[0]};
    end
    if (lr_change && lr_now)
    begin
      left_next = rx_sh_reg;
      tx_sh_next = right_hold_reg;
    end
    if (fall)
    begin
      dac_next = tx_sh_reg[15];
      tx_sh_next = {tx_sh_reg[14:0], 1'b0};
    end
    case (st_reg)
      ARP_ST_IDLE:
      begin
        if (lr_change && !lr_now)
        begin
          tx_sh_next = 16'h0000;
          right_hold_next = 16'h0000;
        end
        // record wins if both buttons land in the same cycle
        if (press[1])
        begin
          st_next = ARP_ST_REC;
          wr_ptr_next = '0;
          len_next = '0;
        end
        else if (press[0] && len_reg != '0)
        begin
          st_next = ARP_ST_PLAY;
          rd_ptr_next = '0;
        end
      end
      ARP_ST_REC:
      begin
        if (lr_change && !lr_now)
        begin
          tx_sh_next = 16'h0000;
          right_hold_next = 16'h0000;
          mem_we = 1'b1;
          wr_ptr_next = wr_ptr_reg + 1'b1;
          len_next = len_reg + LEN_ONE;
          if (wr_ptr_reg == `ARP_BUF_LAST)
            st_next = ARP_ST_IDLE;
        end
        if (press[1])
          st_next = ARP_ST_IDLE;
      end
      default:
      begin
        if (lr_change && !lr_now)
        begin
          tx_sh_next = play_word_reg[31:16];
          right_hold_next = play_word_reg[15:0];
          rd_ptr_next = rd_ptr_reg + 1'b1;
          if ({1'b0, rd_ptr_reg} + LEN_ONE == len_reg)
            st_next = ARP_ST_IDLE;
        end
        if (press[0])
          st_next = ARP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st_reg <= ARP_ST_IDLE;
      bclk_prev_reg <= 1'b0;
      lr_prev_reg <= 1'b0;
      bit_cnt_reg <= 5'h1F;
      rx_sh_reg <= 16'h0000;
      left_reg <= 16'h0000;
      tx_sh_reg <= 16'h0000;
      right_hold_reg <= 16'h0000;
      dac_reg <= 1'b0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      len_reg <= '0;
      rec_led_reg <= 1'b0;
      play_led_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      bclk_prev_reg <= sync_reg[2];
      lr_prev_reg <= lr_prev_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_sh_reg <= rx_sh_next;
      left_reg <= left_next;
      tx_sh_reg <= tx_sh_next;
      right_hold_reg <= right_hold_next;
      dac_reg <= dac_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      len_reg <= len_next;
      rec_led_reg <= (st_next == ARP_ST_REC);
      play_led_reg <= (st_next == ARP_ST_PLAY);
    end
  end

  // buffer has no reset; the length register guards against stale words
  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem[wr_ptr_reg] <= {left_reg, rx_sh_reg};
    play_word_reg <= mem[rd_ptr_reg];
  end

  arp_i2c_cfg u_cfg (
    .clk(clk),
    .rst_sync_n(rst_sync_n),
    .start(cfg_start_reg),
    .mic_select(!set_reg[4]),
    .rate_code(set_reg[3:0]),
    .sda_i(codec_sda_i),
    .scl_oe(codec_scl_oe),
    .sda_oe(codec_sda_oe),
    .busy(codec_cfg_busy),
    .nack(codec_nack)
  );

  // open-drain: only ever pull low; clock stretching is not supported
  assign codec_scl_o = 1'b0;
  assign codec_sda_o = 1'b0;
  assign codec_master_clock_input = nco_reg[31];
  assign codec_dac_data = dac_reg;
  assign recording_indicator = rec_led_reg;
  assign playing_indicator = play_led_reg;
endmodule // arp_top

// [testbench/arp_top_sva.sv]
`timescale 1ns/1ps
module arp_top_chk
#(
  parameter int DEBOUNCE_CYC = 8
)
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic source_select_switch, // switch
  input wire logic rate_select_bit0, // switch
  input wire logic rate_select_bit1, // switch
  input wire logic rate_select_bit2, // switch
  input wire logic record_toggle_button_n, // button
  input wire logic play_toggle_button_n, // button
  input wire logic codec_bclk, // bit clock
  input wire logic codec_lrclk, // frame clock
  input wire logic codec_adc_data, // record data
  input wire logic codec_scl_i, // clock line
  input wire logic codec_sda_i, // data line
  input wire logic recording_indicator, // led
  input wire logic playing_indicator, // led
  input wire logic codec_master_clock_input, // master clock
  input wire logic codec_dac_data, // play data
  input wire logic codec_scl_o, // drive value
  input wire logic codec_scl_oe, // pull low
  input wire logic codec_sda_o, // drive value
  input wire logic codec_sda_oe, // pull low
  input wire logic codec_cfg_busy, // config busy
  input wire logic codec_nack // missed ack
);
  // a toggle must follow a press closely; the window outlasts the lockout
  int rec_win_reg, rec_win_next, play_win_reg, play_win_next;
  // cycles since playback stopped; the last frame still drains after stop
  int quiet_reg, quiet_next;
  always_comb
  begin
    quiet_next = (quiet_reg < 2000) ? quiet_reg + 1 : quiet_reg;
    if (playing_indicator)
      quiet_next = 0;
    rec_win_next = (rec_win_reg > 0) ? rec_win_reg - 1 : 0;
    play_win_next = (play_win_reg > 0) ? play_win_reg - 1 : 0;
    if (!record_toggle_button_n)
      rec_win_next = DEBOUNCE_CYC + 8;
    if (!play_toggle_button_n)
      play_win_next = DEBOUNCE_CYC + 8;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rec_win_reg <= 0;
      play_win_reg <= 0;
      quiet_reg <= 0;
    end
    else
    begin
      quiet_reg <= quiet_next;
      rec_win_reg <= rec_win_next;
      play_win_reg <= play_win_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ind_excl_a: assert property (!(recording_indicator && playing_indicator))
    else $error("both indicators lit");
  rec_cause_a: assert property ($rose(recording_indicator) |-> rec_win_reg != 0)
    else $error("recording began without a press");
  play_cause_a: assert property ($rose(playing_indicator) |-> play_win_reg != 0)
    else $error("playback began without a press");
  dac_idle_a: assert property (quiet_reg > 1100 |->
    !codec_dac_data)
    else $error("playback data active while not playing");
  mclk_high_a: assert property ($rose(codec_master_clock_input) |->
    codec_master_clock_input [*5] ##[1:2] !codec_master_clock_input)
    else $error("master clock high phase wrong");
  mclk_low_a: assert property ($fell(codec_master_clock_input) |->
    !codec_master_clock_input [*5] ##[1:2] codec_master_clock_input)
    else $error("master clock low phase wrong");
  od_value_a: assert property (!codec_scl_o && !codec_sda_o)
    else $error("open drain value not low");
  i2c_start_a: assert property ($rose(codec_sda_oe) && !codec_scl_oe |->
    ##[1:1000] codec_scl_oe)
    else $error("start not followed by clock");
  busy_bus_a: assert property (codec_scl_oe |-> codec_cfg_busy)
    else $error("bus active while idle");
  cover property ($rose(recording_indicator));
  cover property ($rose(playing_indicator));
  cover property ($fell(playing_indicator) && play_win_reg == 0);
  cover property ($rose(codec_sda_oe) && !codec_scl_oe);
endmodule // arp_top_chk

bind arp_top arp_top_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) chk (.*);

// [testbench/arp_codec_model.sv]
`timescale 1ns/1ps
module arp_codec_model
(
  output logic bclk, // bit clock, free running
  output logic lrclk, // frame clock, 0 left
  output logic adc_data, // record data
  output logic ack_oe, // pulls data line low
  input wire logic dac_data, // playback data
  input wire logic scl_oe, // host pulls clock low
  input wire logic sda_oe // host pulls data low
);
  logic [16:0] rx_q[$];
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic [11:0] frame;
  int slot;
  int bits;
  initial
  begin
    bclk = 0;
    lrclk = 1;
    adc_data = 0;
    ack_oe = 0;
    frame = 0;
    slot = 0;
    bits = 0;
    tx_word = 16'h0000;
    rx_word = 16'h0000;
  end
  always #32 bclk = ~bclk;
  // 20 bit clocks a channel, msb one bit clock after the frame edge
  always @(negedge bclk)
  begin
    slot = (slot == 19) ? 0 : slot + 1;
    if (slot == 0)
    begin
      lrclk = ~lrclk;
      frame = frame + {11'h000, ~lrclk};
      tx_word = {lrclk ? 4'h5 : 4'hA, frame};
    end
    adc_data = (slot >= 1 && slot <= 16) ? tx_word[16 - slot] : ~tx_word[0];
  end
  always @(posedge bclk)
  begin
    if (slot >= 1 && slot <= 16)
      rx_word = {rx_word[14:0], dac_data};
    if (slot == 16)
      rx_q.push_back({lrclk, rx_word});
  end
  // acknowledge the ninth bit of every byte
  always @(posedge sda_oe)
    if (!scl_oe)
      bits = 0;
  always @(posedge scl_oe)
  begin
    bits = bits + 1;
    ack_oe = (bits == 9);
    if (bits == 10)
      bits = 1;
  end
endmodule // arp_codec_model

// [testbench/audio_record_play_control_tb_top.sv]
`timescale 1ns/1ps
`include "arp_regs.svh"
module audio_record_play_control_tb_top;
  localparam logic [7:0] CODEC_ADDR = `ARP_CODEC_ADDR;
  logic clk = 0;
  logic rst_n = 0;
  logic record_toggle_button_n = 1;
  logic play_toggle_button_n = 1;
  logic bclk, lrclk, adc_data, ack_oe, scl_i, sda_i, prev;
  logic recording_indicator, playing_indicator, mclk, dac_data;
  logic codec_scl_oe, codec_sda_oe, codec_cfg_busy, codec_nack;
  int err_total = 0;
  int tests_run = 0;
  int i, cnt;
  assign scl_i = ~codec_scl_oe;
  assign sda_i = ~(codec_sda_oe | ack_oe);
  always #2.5 clk = ~clk;
  arp_top #(.DEBOUNCE_CYC(8)) uut (
    .clk(clk), .rst_n(rst_n), .source_select_switch(1'b0),
    .rate_select_bit0(1'b0), .rate_select_bit1(1'b0),
    .rate_select_bit2(1'b0),
    .record_toggle_button_n(record_toggle_button_n),
    .play_toggle_button_n(play_toggle_button_n),
    .codec_bclk(bclk), .codec_lrclk(lrclk), .codec_adc_data(adc_data),
    .codec_scl_i(scl_i), .codec_sda_i(sda_i),
    .recording_indicator(recording_indicator),
    .playing_indicator(playing_indicator),
    .codec_master_clock_input(mclk), .codec_dac_data(dac_data),
    .codec_scl_o(), .codec_scl_oe(codec_scl_oe), .codec_sda_o(),
    .codec_sda_oe(codec_sda_oe), .codec_cfg_busy(codec_cfg_busy),
    .codec_nack(codec_nack));
  arp_codec_model codec (
    .bclk(bclk), .lrclk(lrclk), .adc_data(adc_data), .ack_oe(ack_oe),
    .dac_data(dac_data), .scl_oe(codec_scl_oe), .sda_oe(codec_sda_oe));
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_on(input int sel, input logic val, input int lim);
    logic [3:0] s;
    for (int k = 0; k < lim; k++)
    begin
      @(negedge clk);
      s = {codec_scl_oe, codec_sda_oe, playing_indicator, recording_indicator};
      if (s[sel] === val)
        return;
    end
    err_total++;
    $display("ERROR %0t wait timed out", $time);
    summarize();
  endtask
  task automatic press(input bit play);
    if (play)
      play_toggle_button_n = 0;
    else
      record_toggle_button_n = 0;
    repeat (20) @(negedge clk);
    play_toggle_button_n = 1;
    record_toggle_button_n = 1;
    repeat (20) @(negedge clk);
  endtask
  task automatic check_frames;
    logic [16:0] l, r;
    logic [11:0] n;
    int good;
    bit skip;
    good = 0;
    skip = 1;
    while (codec.rx_q.size() > 1)
    begin
      l = codec.rx_q.pop_front();
      if (l[16])
        continue;
      r = codec.rx_q.pop_front();
      if ({l[15:0], r[15:0]} === 32'h0000_0000)
        continue;
      // the first stored frame may have been cut short
      if (skip)
      begin
        skip = 0;
        continue;
      end
      if (good == 0)
        n = l[11:0];
      check(l, {5'h0A, n});
      check(r, {5'h15, n});
      n++;
      good++;
    end
    check(good > 2, 1);
    $display("test playback done");
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    check({recording_indicator, playing_indicator, codec_sda_oe}, 0);
    rst_n = 1;
    wait_on(2, 1, 3000);
    check(codec_scl_oe, 0);
    for (i = 7; i >= 0; i--)
    begin
      wait_on(3, 1, 3000);
      wait_on(3, 0, 3000);
      check(codec_sda_oe, !CODEC_ADDR[i]);
    end
    wait_on(3, 1, 3000);
    wait_on(3, 0, 3000);
    check(sda_i, 0);
    wait_on(3, 1, 3000);
    check(codec_nack, 0);
    $display("test config done");
    cnt = 0;
    prev = mclk;
    repeat (10000)
    begin
      @(negedge clk);
      if (mclk && !prev)
        cnt++;
      prev = mclk;
    end
    check(cnt >= 921 && cnt <= 922, 1);
    $display("test master clock done");
    press(1);
    check(playing_indicator, 0);
    press(0);
    check(recording_indicator, 1);
    repeat (3000) @(negedge clk);
    press(1);
    check({recording_indicator, playing_indicator}, 2'b10);
    press(0);
    check(recording_indicator, 0);
    $display("test record done");
    codec.rx_q.delete();
    press(1);
    check(playing_indicator, 1);
    wait_on(1, 0, 20000);
    // the last frame is still on the link when the indicator drops
    repeat (1100) @(negedge clk);
    check_frames();
    press(1);
    check(playing_indicator, 1);
    repeat (300) @(negedge clk);
    press(1);
    check(playing_indicator, 0);
    $display("test play toggle done");
    summarize();
  end
endmodule // audio_record_play_control_tb_top
